// [bench/panel_props.sv]
`timescale 1ns/10ps

// ----
// Port checker for the front panel block.
// ----
module panel_props
  import panel_pkg::*;
#(
  parameter int NUM_LAMP = 8,
  parameter int LAMP_FITTED = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Protection and operator inputs.
  input wire prot_in_type prot_in,
  input wire logic clear_key,
  input wire logic reset_input,
  input wire logic sync_clear,
  // Indications.
  input wire logic [NUM_LAMP-1:0] lamp_red,
  input wire logic trip_lamp,
  input wire logic oos_lamp,
  input wire logic healthy_lamp,
  input wire logic watchdog_ok
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Bus handshake: one access cycle, error only with ready.
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");

  // Trip lamp set and clear paths.
  a_trip_sets: assert property (
    prot_in.trip_issue && !sync_clear |=> trip_lamp)
    else $error("trip lamp not lit after trip");
  a_trip_clears: assert property (
    (clear_key || reset_input) && !prot_in.trip_issue |=> !trip_lamp)
    else $error("trip lamp not cleared by reset");
  a_sync_clears: assert property (
    sync_clear && !prot_in.trip_issue |=> !trip_lamp)
    else $error("trip lamp not cleared by sync clear");

  // The first edge after reset release is skipped by the past check.
  a_oos_follow: assert property (
    $past(rst_n) |-> oos_lamp == $past(prot_in.out_of_service))
    else $error("out of service lamp wrong");
  a_healthy_fault: assert property (
    $past(rst_n) |-> healthy_lamp == !$past(prot_in.self_test_fault))
    else $error("healthy lamp wrong");
  a_watchdog_mirror: assert property (
    watchdog_ok == healthy_lamp)
    else $error("watchdog differs from healthy lamp");
  a_unfitted_dark: assert property (
    (lamp_red >> LAMP_FITTED) == '0)
    else $error("unfitted lamp lit");

  // Main scenarios reached.
  c_bus_error: cover property (psel && penable && pready && pslverr);
  c_trip: cover property (prot_in.trip_issue ##1 trip_lamp);
  c_trip_off: cover property ($fell(trip_lamp));
  c_fault: cover property (healthy_lamp ##1 !healthy_lamp);
endmodule

bind front_panel_indication_keys panel_props #(
  .NUM_LAMP(NUM_LAMP),
  .LAMP_FITTED(LAMP_FITTED)
) u_props (
  .core_clk, .rst_n, .psel, .penable, .pready, .pslverr, .prot_in,
  .clear_key, .reset_input, .sync_clear, .lamp_red, .trip_lamp,
  .oos_lamp, .healthy_lamp, .watchdog_ok
);

// [bench/testbench.sv]
`timescale 1ns/10ps
`include "panel_defs.svh"

// ----
// Self-checking bench for the front panel block.
// ----
module testbench;
  import panel_pkg::*;
  localparam int LF = 4;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic clear_key, reset_input, sync_clear;
  logic trip_lamp, alarm_lamp, oos_lamp, healthy_lamp, watchdog_ok;
  logic [7:0] paddr, lamp_drive, tri_red_drive, tri_green_drive;
  logic [7:0] contact_drive, lamp_red, tri_red, tri_green, contact_out;
  logic [31:0] pwdata, prdata, control_inputs, rdat, rnd, obs;
  logic [9:0] key_pressed, key_state_vector;
  logic [3:0] got;
  prot_in_type prot_in;
  int fails, checked, cycles, seed, ones;

  // Short tick and timers keep the run brief; four lamps fitted.
  front_panel_indication_keys #(.LAMP_FITTED(LF), .TICK_CYCLES(4),
    .SELF_RESET_TICKS(5), .FLASH_TICKS(2)) u_dut (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .prot_in, .clear_key, .reset_input,
    .sync_clear, .lamp_drive, .tri_red_drive, .tri_green_drive,
    .contact_drive, .key_pressed, .trip_lamp, .alarm_lamp, .oos_lamp,
    .healthy_lamp, .watchdog_ok, .lamp_red, .tri_red, .tri_green,
    .contact_out, .key_state_vector, .control_inputs);

  // Clock at 250 MHz.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // A hung handshake ends the run as a failure.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict;
    end
  end

  // ----
  // Tasks
  // ----
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Request is held until ready is seen at a rising edge.
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic trip_pulse;
    @(posedge core_clk);
    prot_in.trip_issue <= 1'b1;
    @(posedge core_clk);
    prot_in.trip_issue <= 1'b0;
    cyc(2);
    chk("trip lamp on", 32'(trip_lamp), 32'h1);
  endtask

  // Reclose after a dead period, optionally with pickup afterwards.
  task automatic self_case(input logic en, pick, exp);
    apb(`OFS_SYS_LINKS, 1'b1, {31'h0, en});
    trip_pulse;
    prot_in.any_phase_dead <= 1'b1;
    cyc(3);
    prot_in.any_phase_dead <= 1'b0;
    prot_in.any_prot_pickup <= pick;
    cyc(40);
    chk("self reset", 32'(trip_lamp), 32'(exp));
    prot_in.any_prot_pickup <= 1'b0;
    reset_input <= 1'b1;
    cyc(1);
    reset_input <= 1'b0;
    cyc(2);
  endtask

  // Contact samples: on early, on late, off early, off late.
  function automatic logic [3:0] con_exp(input int m);
    case (m)
      0: return 4'b1100;
      1: return 4'b1111;
      2: return 4'b0100;
      default: return 4'b1110;
    endcase
  endfunction

  // ----
  // Main sequence
  // ----
  initial begin
    seed = 84;
    {psel, penable, pwrite, paddr, pwdata, clear_key} = '0;
    {reset_input, sync_clear, lamp_drive, tri_red_drive} = '0;
    {tri_green_drive, contact_drive, key_pressed, prot_in} = '0;
    rst_n = 1'b0;
    cyc(20);
    rst_n <= 1'b1;
    apb(`OFS_SYS_LINKS, 1'b0, 32'h0);
    chk("links reset", rdat, 32'h0);
    apb(8'h30, 1'b1, 32'h1);
    chk("unmapped error", 32'(rerr), 32'h1);
    apb(8'h30, 1'b0, 32'h0);
    chk("unmapped data", rdat, 32'h0);
    for (int i = 0; i < 3; i++) begin
      trip_pulse;
      {sync_clear, reset_input, clear_key} <= 3'(1 << i);
      cyc(1);
      {sync_clear, reset_input, clear_key} <= 3'h0;
      cyc(2);
      chk("trip cleared", 32'(trip_lamp), 32'h0);
    end
    self_case(1'b1, 1'b0, 1'b0);
    self_case(1'b0, 1'b0, 1'b1);
    self_case(1'b1, 1'b1, 1'b1);
    $display("trip tests done");
    prot_in.new_alarm <= 1'b1;
    cyc(1);
    prot_in.new_alarm <= 1'b0;
    ones = 0;
    repeat (24) begin
      @(posedge core_clk);
      ones += int'(alarm_lamp === 1'b1);
    end
    chk("alarm flashing", 32'(ones > 0 && ones < 24), 32'h1);
    prot_in.alarm_accept <= 1'b1;
    cyc(1);
    prot_in.alarm_accept <= 1'b0;
    cyc(2);
    ones = 0;
    repeat (12) begin
      @(posedge core_clk);
      ones += int'(alarm_lamp === 1'b1);
    end
    chk("alarm steady", 32'(ones), 32'd12);
    apb(`OFS_STATUS, 1'b0, 32'h0);
    chk("alarm state", 32'(rdat[3:2]), 32'h2);
    prot_in.alarm_clear_all <= 1'b1;
    cyc(1);
    prot_in.alarm_clear_all <= 1'b0;
    cyc(2);
    chk("alarm dark", 32'(alarm_lamp), 32'h0);
    $display("alarm tests done");
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      {prot_in.self_test_fault, prot_in.out_of_service} <= rnd[25:24];
      {tri_green_drive, tri_red_drive, lamp_drive} <= rnd[23:0];
      cyc(2);
      chk("single lamps", 32'(lamp_red), 32'(rnd[LF-1:0]));
      chk("tri", 32'({tri_green, tri_red}), 32'(rnd[23:8]));
      chk("oos lamp", 32'(oos_lamp), 32'(rnd[24]));
      chk("healthy", 32'(healthy_lamp), 32'(!rnd[25]));
    end
    // The latches have gathered every random drive above; empty them.
    {tri_green_drive, tri_red_drive, lamp_drive} <= 24'h0;
    apb(`OFS_OP_RESET, 1'b1, 32'h1);
    apb(`OFS_LAMP_LATCH, 1'b1, 32'h00FF_00FF);
    {tri_green_drive, tri_red_drive, lamp_drive} <= 24'h01_02_F5;
    cyc(2);
    {tri_green_drive, tri_red_drive, lamp_drive} <= 24'h0;
    cyc(2);
    obs = 32'({tri_green, tri_red, lamp_red});
    chk("latched lamps", obs, 32'h010205);
    apb(`OFS_OP_RESET, 1'b1, 32'h1);
    cyc(2);
    obs = 32'({tri_green, tri_red, lamp_red});
    chk("lamps reset", obs, 32'h0);
    $display("lamp tests done");
    apb(`OFS_CONTACT_DELAY, 1'b1, 32'h3);
    for (int m = 0; m < 4; m++) begin
      apb(`OFS_CONTACT_MODE, 1'b1, 32'(m));
      rnd = $random(seed);
      contact_drive <= {rnd[7:1], 1'b1};
      cyc(2);
      got[3] = contact_out[0];
      cyc(20);
      got[2] = contact_out[0];
      contact_drive <= 8'h00;
      cyc(2);
      got[1] = contact_out[0];
      cyc(20);
      got[0] = contact_out[0];
      chk("contact sequence", 32'(got), 32'(con_exp(m)));
      apb(`OFS_OP_RESET, 1'b1, 32'h2);
      cyc(2);
      chk("contact cleared", 32'(contact_out), 32'h0);
    end
    $display("contact tests done");
    apb(`OFS_KEY_MODE, 1'b1, 32'h1);
    apb(`OFS_KEY_PULSE, 1'b1, 32'h3);
    for (int i = 0; i < 2; i++) begin
      key_pressed <= 10'h001;
      cyc(1);
      key_pressed <= 10'h000;
      cyc(3);
      chk("toggle", 32'(key_state_vector), 32'h1);
      apb(`OFS_KEY_LOCK, 1'b1, 32'(i * 3));
      apb(`OFS_OP_RESET, 1'b1, 32'h4);
      cyc(2);
      chk("reset", 32'(key_state_vector), 32'(i));
    end
    key_pressed <= 10'h002;
    cyc(30);
    chk("locked normal key", 32'(key_state_vector), 32'h1);
    apb(`OFS_KEY_LOCK, 1'b1, 32'h0);
    apb(`OFS_OP_RESET, 1'b1, 32'h4);
    cyc(2);
    chk("held normal key", 32'(key_state_vector), 32'h2);
    key_pressed <= 10'h000;
    cyc(3);
    chk("released key", 32'(key_state_vector), 32'h0);
    key_pressed <= 10'h002;
    cyc(1);
    key_pressed <= 10'h000;
    cyc(3);
    chk("pulse on", 32'(key_state_vector), 32'h2);
    cyc(20);
    chk("pulse over", 32'(key_state_vector), 32'h0);
    apb(`OFS_KEY_STATE, 1'b1, 32'h1);
    apb(`OFS_KEY_STATE, 1'b0, 32'h0);
    chk("key restore", rdat, 32'h1);
    $display("key tests done");
    rnd = $random(seed);
    apb(`OFS_CTRL_IN, 1'b1, rnd);
    cyc(2);
    chk("control inputs", control_inputs, rnd);
    apb(`OFS_CTRL_IN, 1'b0, 32'h0);
    chk("control readback", rdat, rnd);
    $display("control tests done");
    give_verdict;
  end
endmodule

// [src/front_panel_indication_keys.sv]
`timescale 1ns/10ps
`include "panel_defs.svh"

module front_panel_indication_keys
  import panel_pkg::*;
#(
  parameter int NUM_LAMP = 8,
  parameter int LAMP_FITTED = 8,
  parameter int NUM_TRI = 8,
  parameter int TRI_FITTED = 8,
  parameter int NUM_CONTACT = 8,
  parameter int NUM_KEY = 10,
  parameter int TICK_CYCLES =
    `TICK_PERIOD_NS / `CORE_CLK_PERIOD_NS,
  parameter int SELF_RESET_TICKS = `SELF_RESET_MS,
  parameter int FLASH_TICKS = `FLASH_HALF_MS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protection signals, operator inputs and synchronous clear.
  input wire prot_in_type prot_in,
  input wire logic clear_key,
  input wire logic reset_input,
  input wire logic sync_clear,
  // Lamp and contact drives from the internal signal bus, and key presses.
  input wire logic [NUM_LAMP-1:0] lamp_drive,
  input wire logic [NUM_TRI-1:0] tri_red_drive,
  input wire logic [NUM_TRI-1:0] tri_green_drive,
  input wire logic [NUM_CONTACT-1:0] contact_drive,
  input wire logic [NUM_KEY-1:0] key_pressed,
  // Fixed lamps and watchdog.
  output logic trip_lamp,
  output logic alarm_lamp,
  output logic oos_lamp,
  output logic healthy_lamp,
  output logic watchdog_ok,
  // Programmable lamps, contacts, keys and control inputs.
  output logic [NUM_LAMP-1:0] lamp_red,
  output logic [NUM_TRI-1:0] tri_red,
  output logic [NUM_TRI-1:0] tri_green,
  output logic [NUM_CONTACT-1:0] contact_out,
  output logic [NUM_KEY-1:0] key_state_vector,
  output logic [31:0] control_inputs
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [15:0] SR_LAST = 16'(SELF_RESET_TICKS);
  localparam logic [15:0] FLASH_LAST = 16'(FLASH_TICKS - 1);
  localparam logic [NUM_LAMP-1:0] LAMP_MASK =
    NUM_LAMP'((64'h1 << LAMP_FITTED) - 64'h1);
  localparam logic [NUM_TRI-1:0] TRI_MASK =
    NUM_TRI'((64'h1 << TRI_FITTED) - 64'h1);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [TW-1:0] pre;
    logic tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic self_en;
    logic [31:0] lamp_latch_cfg;
    logic [2*NUM_CONTACT-1:0] contact_mode;
    logic [15:0] contact_delay;
    logic [NUM_KEY-1:0] key_mode;
    logic [NUM_KEY-1:0] key_lock;
    logic [15:0] key_pulse;
    logic [31:0] ctrl_in;
    logic trip_lamp;
    logic dead_seen;
    logic sr_block;
    logic [15:0] sr_cnt;
    alarm_state_type alarm_st;
    logic [15:0] flash_cnt;
    logic flash_ph;
    logic alarm_lamp;
    logic oos_lamp;
    logic healthy;
    logic [NUM_LAMP-1:0] lamp_lat;
    logic [NUM_LAMP-1:0] lamp_out;
    logic [NUM_TRI-1:0] red_lat;
    logic [NUM_TRI-1:0] grn_lat;
    logic [NUM_TRI-1:0] red_out;
    logic [NUM_TRI-1:0] grn_out;
    logic [NUM_CONTACT-1:0] con_out;
    logic [NUM_CONTACT-1:0][15:0] con_cnt;
    logic [NUM_KEY-1:0] key_prev;
    logic [NUM_KEY-1:0] key_out;
    logic [NUM_KEY-1:0][15:0] key_cnt;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic wr_en;
  logic setup;
  logic rst_lamps;
  logic rst_cons;
  logic rst_keys;
  logic trip_clear;
  logic [NUM_LAMP-1:0] lamp_eff;
  logic [NUM_TRI-1:0] red_eff;
  logic [NUM_TRI-1:0] grn_eff;
  logic [NUM_KEY-1:0] press;
  contact_mode_type cmode;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  // One process computes the whole next state; the register below
  // holds it, so every output is a flip-flop.
  always_comb begin
    s_nxt = s_r;
    cmode = CONTACT_FOLLOW;
    // Timer tick divider; all slow timers advance on this pulse.
    s_nxt.tick = (s_r.pre == TICK_LAST);
    s_nxt.pre = s_nxt.tick ? '0 : TW'(s_r.pre + 1'b1);
    // APB: the read word is prepared in setup and shown with pready
    // in the single access cycle, so the slave has no wait states.
    setup = psel & ~penable;
    wr_en = psel & penable & pwrite & s_r.pready;
    s_nxt.pready = setup;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        `OFS_SYS_LINKS: s_nxt.prdata = {31'h0, s_r.self_en};
        `OFS_LAMP_LATCH: s_nxt.prdata = s_r.lamp_latch_cfg;
        `OFS_OP_RESET: s_nxt.prdata = 32'h0000_0000;
        `OFS_CONTACT_MODE: s_nxt.prdata = 32'(s_r.contact_mode);
        `OFS_CONTACT_DELAY: s_nxt.prdata = {16'h0, s_r.contact_delay};
        `OFS_KEY_MODE: s_nxt.prdata = 32'(s_r.key_mode);
        `OFS_KEY_LOCK: s_nxt.prdata = 32'(s_r.key_lock);
        `OFS_KEY_PULSE: s_nxt.prdata = {16'h0, s_r.key_pulse};
        `OFS_KEY_STATE: s_nxt.prdata = 32'(s_r.key_out);
        `OFS_CTRL_IN: s_nxt.prdata = s_r.ctrl_in;
        `OFS_STATUS: s_nxt.prdata = {25'h0, s_r.healthy, s_r.oos_lamp,
          s_r.alarm_lamp, s_r.alarm_st, s_r.sr_block, s_r.trip_lamp};
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    // Configuration writes; unmapped writes change nothing.
    rst_lamps = sync_clear;
    rst_cons = sync_clear;
    rst_keys = 1'b0;
    if (wr_en) begin
      case (paddr)
        `OFS_SYS_LINKS: s_nxt.self_en = pwdata[`BIT_SELF_RESET];
        `OFS_LAMP_LATCH: s_nxt.lamp_latch_cfg = pwdata;
        `OFS_OP_RESET: begin
          rst_lamps = rst_lamps | pwdata[`BIT_RST_LAMPS];
          rst_cons = rst_cons | pwdata[`BIT_RST_CONTACTS];
          rst_keys = pwdata[`BIT_RST_KEYS];
        end
        `OFS_CONTACT_MODE: s_nxt.contact_mode = pwdata[2*NUM_CONTACT-1:0];
        `OFS_CONTACT_DELAY: s_nxt.contact_delay = pwdata[15:0];
        `OFS_KEY_MODE: s_nxt.key_mode = pwdata[NUM_KEY-1:0];
        `OFS_KEY_LOCK: s_nxt.key_lock = pwdata[NUM_KEY-1:0];
        `OFS_KEY_PULSE: s_nxt.key_pulse = pwdata[15:0];
        `OFS_CTRL_IN: s_nxt.ctrl_in = pwdata;
        default: s_nxt.ctrl_in = s_r.ctrl_in;
      endcase
    end
    // Trip lamp self-reset: remember the pole opened, then count the
    // closed time; a pickup while closed blocks until the next open.
    trip_clear = clear_key | reset_input | sync_clear;
    if (!s_r.trip_lamp || prot_in.any_phase_dead) begin
      s_nxt.sr_cnt = 16'h0000;
      s_nxt.sr_block = 1'b0;
      s_nxt.dead_seen = s_r.trip_lamp & prot_in.any_phase_dead;
    end else begin
      if (prot_in.any_prot_pickup) begin
        s_nxt.sr_block = 1'b1;
      end
      if (s_r.tick && s_r.sr_cnt != SR_LAST) begin
        s_nxt.sr_cnt = s_r.sr_cnt + 16'h0001;
      end
    end
    if (s_r.self_en && s_r.dead_seen && !s_r.sr_block &&
        !prot_in.any_prot_pickup && s_r.sr_cnt == SR_LAST) begin
      trip_clear = 1'b1;
    end
    if (sync_clear) begin
      s_nxt.sr_cnt = 16'h0000;
      s_nxt.dead_seen = 1'b0;
    end
    // A trip in the clearing cycle keeps the lamp lit.
    if (prot_in.trip_issue) begin
      s_nxt.trip_lamp = 1'b1;
    end else if (trip_clear) begin
      s_nxt.trip_lamp = 1'b0;
    end
    // Alarm lamp: a new alarm beats an accept or clear in the same
    // cycle so it is never silently lost.
    case (s_r.alarm_st)
      ALARM_OFF: begin
        if (prot_in.new_alarm) begin
          s_nxt.alarm_st = ALARM_FLASH;
        end
      end
      ALARM_FLASH: begin
        if (prot_in.new_alarm) begin
          s_nxt.alarm_st = ALARM_FLASH;
        end else if (prot_in.alarm_clear_all) begin
          s_nxt.alarm_st = ALARM_OFF;
        end else if (prot_in.alarm_accept) begin
          s_nxt.alarm_st = ALARM_STEADY;
        end
      end
      ALARM_STEADY: begin
        if (prot_in.new_alarm) begin
          s_nxt.alarm_st = ALARM_FLASH;
        end else if (prot_in.alarm_clear_all) begin
          s_nxt.alarm_st = ALARM_OFF;
        end
      end
      default: s_nxt.alarm_st = ALARM_OFF;
    endcase
    if (s_r.tick) begin
      if (s_r.flash_cnt >= FLASH_LAST) begin
        s_nxt.flash_cnt = 16'h0000;
        s_nxt.flash_ph = ~s_r.flash_ph;
      end else begin
        s_nxt.flash_cnt = s_r.flash_cnt + 16'h0001;
      end
    end
    s_nxt.alarm_lamp = (s_r.alarm_st == ALARM_STEADY) |
      ((s_r.alarm_st == ALARM_FLASH) & s_r.flash_ph);
    // Out-of-service and healthy lamps; watchdog shares the flop.
    s_nxt.oos_lamp = prot_in.out_of_service;
    s_nxt.healthy = ~prot_in.self_test_fault;
    // Programmable lamps; unfitted positions are masked off at entry.
    lamp_eff = lamp_drive & LAMP_MASK;
    red_eff = tri_red_drive & TRI_MASK;
    grn_eff = tri_green_drive & TRI_MASK;
    // Set wins over the operator reset in the same cycle.
    s_nxt.lamp_lat = (rst_lamps ? '0 : s_r.lamp_lat) | lamp_eff;
    s_nxt.red_lat = (rst_lamps ? '0 : s_r.red_lat) | red_eff;
    s_nxt.grn_lat = (rst_lamps ? '0 : s_r.grn_lat) | grn_eff;
    for (int i = 0; i < NUM_LAMP; i++) begin
      s_nxt.lamp_out[i] = s_r.lamp_latch_cfg[i] ?
        s_r.lamp_lat[i] : lamp_eff[i];
    end
    for (int i = 0; i < NUM_TRI; i++) begin
      s_nxt.red_out[i] = s_r.lamp_latch_cfg[16+i] ?
        s_r.red_lat[i] : red_eff[i];
      s_nxt.grn_out[i] = s_r.lamp_latch_cfg[16+i] ?
        s_r.grn_lat[i] : grn_eff[i];
    end
    // Output contact conditioners with one shared delay setting.
    for (int i = 0; i < NUM_CONTACT; i++) begin
      cmode = contact_mode_type'(s_r.contact_mode[2*i +: 2]);
      case (cmode)
        CONTACT_FOLLOW: begin
          s_nxt.con_out[i] = contact_drive[i];
          s_nxt.con_cnt[i] = 16'h0000;
        end
        CONTACT_LATCH: begin
          s_nxt.con_out[i] = (s_r.con_out[i] & ~rst_cons) |
            contact_drive[i];
        end
        CONTACT_PICKUP: begin
          if (!contact_drive[i]) begin
            s_nxt.con_cnt[i] = 16'h0000;
            s_nxt.con_out[i] = 1'b0;
          end else if (s_r.con_cnt[i] >= s_r.contact_delay) begin
            s_nxt.con_out[i] = 1'b1;
          end else if (s_r.tick) begin
            s_nxt.con_cnt[i] = s_r.con_cnt[i] + 16'h0001;
          end
        end
        CONTACT_DROPOFF: begin
          if (contact_drive[i]) begin
            s_nxt.con_cnt[i] = 16'h0000;
            s_nxt.con_out[i] = 1'b1;
          end else if (s_r.con_cnt[i] >= s_r.contact_delay) begin
            s_nxt.con_out[i] = 1'b0;
          end else if (s_r.tick) begin
            s_nxt.con_cnt[i] = s_r.con_cnt[i] + 16'h0001;
          end
        end
        default: s_nxt.con_out[i] = contact_drive[i];
      endcase
      if (sync_clear) begin
        s_nxt.con_cnt[i] = 16'h0000;
      end
    end
    // Function keys. A locked toggle key ignores presses and resets,
    // so an active function cannot be knocked off by accident.
    press = key_pressed & ~s_r.key_prev;
    s_nxt.key_prev = key_pressed;
    for (int i = 0; i < NUM_KEY; i++) begin
      if (s_r.key_mode[i]) begin
        s_nxt.key_cnt[i] = 16'h0000;
        if (s_r.key_lock[i]) begin
          s_nxt.key_out[i] = s_r.key_out[i];
        end else if (press[i]) begin
          s_nxt.key_out[i] = 1'b1;
        end else if (rst_keys) begin
          s_nxt.key_out[i] = 1'b0;
        end
      end else if (s_r.key_lock[i] || sync_clear) begin
        s_nxt.key_out[i] = 1'b0;
        s_nxt.key_cnt[i] = 16'h0000;
      end else begin
        if (press[i]) begin
          s_nxt.key_cnt[i] = s_r.key_pulse;
        end else if (s_r.tick && s_r.key_cnt[i] != 16'h0000) begin
          s_nxt.key_cnt[i] = s_r.key_cnt[i] - 16'h0001;
        end
        s_nxt.key_out[i] = key_pressed[i] |
          (s_r.key_cnt[i] != 16'h0000);
      end
    end
    // Restore of the saved vector after a supply interruption; normal
    // keys fall back to their live state on the next cycle.
    if (wr_en && paddr == `OFS_KEY_STATE) begin
      s_nxt.key_out = pwdata[NUM_KEY-1:0];
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Every field takes a constant under the asynchronous reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.self_en <= `RST_SYS_LINKS;
      s_r.lamp_latch_cfg <= `RST_WORD;
      s_r.ctrl_in <= `RST_WORD;
      s_r.contact_delay <= `RST_DELAY;
      s_r.key_pulse <= `RST_DELAY;
      s_r.alarm_st <= ALARM_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // All outputs are fields of the state register.
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign trip_lamp = s_r.trip_lamp;
  assign alarm_lamp = s_r.alarm_lamp;
  assign oos_lamp = s_r.oos_lamp;
  assign healthy_lamp = s_r.healthy;
  assign watchdog_ok = s_r.healthy;
  assign lamp_red = s_r.lamp_out;
  assign tri_red = s_r.red_out;
  assign tri_green = s_r.grn_out;
  assign contact_out = s_r.con_out;
  assign key_state_vector = s_r.key_out;
  assign control_inputs = s_r.ctrl_in;

endmodule

// [src/panel_defs.svh]
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH

// Register byte offsets on the APB window.
`define OFS_SYS_LINKS 8'h00
`define OFS_LAMP_LATCH 8'h04
`define OFS_OP_RESET 8'h08
`define OFS_CONTACT_MODE 8'h0C
`define OFS_CONTACT_DELAY 8'h10
`define OFS_KEY_MODE 8'h14
`define OFS_KEY_LOCK 8'h18
`define OFS_KEY_PULSE 8'h1C
`define OFS_KEY_STATE 8'h20
`define OFS_CTRL_IN 8'h24
`define OFS_STATUS 8'h28

// Field positions.
`define BIT_SELF_RESET 0
`define BIT_RST_LAMPS 0
`define BIT_RST_CONTACTS 1
`define BIT_RST_KEYS 2

// Reset values.
`define RST_SYS_LINKS 1'b0
`define RST_WORD 32'h0000_0000
`define RST_DELAY 16'h0000

// Timing: clock period, tick period, self-reset hold, flash half period.
`define CORE_CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 1000000
`define SELF_RESET_MS 3000
`define FLASH_HALF_MS 250

`endif

// [src/panel_pkg.sv]
package panel_pkg;

  // Alarm lamp sequencing.
  typedef enum logic [1:0] {
    ALARM_OFF = 2'b00,
    ALARM_FLASH = 2'b01,
    ALARM_STEADY = 2'b10
  } alarm_state_type;

  // Output contact conditioner behaviour, two bits per contact.
  typedef enum logic [1:0] {
    CONTACT_FOLLOW = 2'b00,
    CONTACT_LATCH = 2'b01,
    CONTACT_PICKUP = 2'b10,
    CONTACT_DROPOFF = 2'b11
  } contact_mode_type;

  // Protection-side signals taken from the internal signal bus.
  typedef struct packed {
    logic trip_issue;
    logic any_phase_dead;
    logic any_prot_pickup;
    logic new_alarm;
    logic alarm_accept;
    logic alarm_clear_all;
    logic out_of_service;
    logic self_test_fault;
  } prot_in_type;

endpackage
